// ---- hw/ultc_top.sv ----
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Resistors follow selected mode, no trimming
// - Decode uses five register-held fields
// - Strong lift enables 1.5k pull-ups
// - Ground leg enables 15k pull-downs
// - HS termination on both lines
// - Operation code 01b clears all enables
// - Power-up setting enables pull-downs only
// - Host chirp/HS: pull-downs plus termination
// - Host FS modes: pull-downs only
// - Host LS modes: pull-downs only
// - Peripheral chirp: DP pull-up only
// - Peripheral HS/test: termination only
// - Peripheral FS modes: DP pull-up only
// - Peripheral LS modes: DM pull-up only
// - OTG peripheral adds DM pull-down in chirp, HS and FS modes; LS modes clear all enables
// - Undefined combinations clear all enables
// - Receiver selected by mode through mux
// - Squelch gates HS receive valid
// - Transmit encodes, stuffs, serializes data
// - Swing setting drives HS amplitude
// - VBUS charge and drain controls
module ultc_top
   import ultc_pkg::*;
#(
   parameter int BOOST_W = 3
) (
   input  wire logic               clk_i,                 // 100 MHz clock
   input  wire logic               reset_i,               // Sync reset, high
   input  wire logic               clk_en_i,              // Freezes state when low
   input  wire logic               psel_i,                // APB select
   input  wire logic               penable_i,             // APB enable
   input  wire logic               pwrite_i,              // APB direction
   input  wire logic [11:0]        paddr_i,               // APB address
   input  wire logic [31:0]        pwdata_i,              // APB write data
   output logic      [31:0]        prdata_o,              // APB read data
   output logic                    pready_o,              // APB ready
   output logic                    pslverr_o,             // APB error
   input  wire logic               hs_rx_data_i,          // HS receiver bit
   input  wire logic               fsls_rx_data_i,        // FS/LS differential bit
   input  wire logic               squelch_i,             // High: no HS signal
   input  wire logic               se_dp_i,               // DP single-ended receiver
   input  wire logic               se_dm_i,               // DM single-ended receiver
   input  wire logic               tx_valid_i,            // Transmit byte valid
   input  wire logic [7:0]         tx_data_i,             // Transmit byte
   output logic                    tx_ready_o,            // Byte accepted
   output logic                    rx_bit_o,              // Selected receive bit
   output logic                    rx_bit_valid_o,        // Receive bit valid
   output logic [1:0]              line_state_o,          // {DM,DP} line state
   output logic                    hs_tx_en_o,            // HS transmitter enable
   output logic                    fsls_tx_en_o,          // FS/LS transmitter enable
   output logic                    tx_line_o,             // NRZI line level
   output logic [BOOST_W-1:0]      hs_swing_adjust_o,     // HS amplitude setting
   output logic                    plus_line_strong_lift_o,  // DP 1.5k pull-up
   output logic                    minus_line_strong_lift_o, // DM 1.5k pull-up
   output logic                    plus_line_ground_leg_o,   // DP 15k pull-down
   output logic                    minus_line_ground_leg_o,  // DM 15k pull-down
   output logic                    hs_line_termination_o,    // 45 ohm termination
   output logic                    vbus_charge_o,         // VBUS pull-up on
   output logic                    vbus_drain_o           // VBUS pull-down on
);
   import ultc_pkg::*;

   initial begin
      if (BOOST_W < 1 || BOOST_W > 8) begin
         $error("BOOST_W must be 1..8");
      end
   end

   logic [5:0]         func_q;
   logic [3:0]         otg_q;
   logic [BOOST_W-1:0] boost_q;
   logic [4:0]         enables;
   logic               wr_stb;
   logic               rd_stb;
   logic [31:0]        rd_d;
   logic               err_d;
   logic [1:0]         xs;
   logic [1:0]         op;
   logic               tx_enable;

   assign xs        = func_q[ULTC_XS_LSB +: 2];
   assign op        = func_q[ULTC_OP_LSB +: 2];
   assign tx_enable = func_q[ULTC_TXEN_BIT];
   assign wr_stb    = psel_i && penable_i && pwrite_i && clk_en_i;
   assign rd_stb    = psel_i && penable_i && !pwrite_i && clk_en_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         func_q  <= ULTC_FUNC_RST;
         otg_q   <= ULTC_OTG_RST;
         boost_q <= BOOST_W'(ULTC_BOOST_RST);
      end else if (wr_stb) begin
         if (paddr_i == ULTC_ADDR_FUNC) begin
            func_q <= pwdata_i[5:0];
         end else if (paddr_i == ULTC_ADDR_OTG) begin
            otg_q <= pwdata_i[3:0];
         end else if (paddr_i == ULTC_ADDR_BOOST) begin
            boost_q <= pwdata_i[BOOST_W-1:0];
         end
      end
   end

   always_comb begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      if (paddr_i == ULTC_ADDR_FUNC) begin
         rd_d[5:0] = func_q;
      end else if (paddr_i == ULTC_ADDR_OTG) begin
         rd_d[3:0] = otg_q;
      end else if (paddr_i == ULTC_ADDR_BOOST) begin
         rd_d[BOOST_W-1:0] = boost_q;
      end else if (paddr_i == ULTC_ADDR_STATUS) begin
         rd_d[ULTC_ST_RES_LSB +: 5]  = {plus_line_strong_lift_o, minus_line_strong_lift_o,
                                        plus_line_ground_leg_o, minus_line_ground_leg_o,
                                        hs_line_termination_o};
         rd_d[ULTC_ST_SQ_BIT]        = squelch_i;
         rd_d[ULTC_ST_LS_LSB +: 2]   = line_state_o;
      end else begin
         err_d = 1'b1;
      end
   end

   // Answer in the cycle after setup, so pready is a flop
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else if (clk_en_i) begin
         pready_o  <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && err_d;
         if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_d;
         end
      end
   end

   ultc_decode u_decode (
      .speed_class_select_i      (xs),
      .fs_termination_choice_i   (func_q[ULTC_TERM_BIT]),
      .drive_operation_code_i    (op),
      .plus_line_sink_request_i  (otg_q[ULTC_DPPD_BIT]),
      .minus_line_sink_request_i (otg_q[ULTC_DMPD_BIT]),
      .enables_o                 (enables)
   );

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         plus_line_strong_lift_o  <= 1'b0;
         minus_line_strong_lift_o <= 1'b0;
         plus_line_ground_leg_o   <= 1'b0;
         minus_line_ground_leg_o  <= 1'b0;
         hs_line_termination_o    <= 1'b0;
      end else if (clk_en_i) begin
         plus_line_strong_lift_o  <= enables[ULTC_R_PUDP];
         minus_line_strong_lift_o <= enables[ULTC_R_PUDM];
         plus_line_ground_leg_o   <= enables[ULTC_R_PDDP];
         minus_line_ground_leg_o  <= enables[ULTC_R_PDDM];
         hs_line_termination_o    <= enables[ULTC_R_HST];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         vbus_charge_o     <= 1'b0;
         vbus_drain_o      <= 1'b0;
         hs_swing_adjust_o <= BOOST_W'(ULTC_BOOST_RST);
      end else if (clk_en_i) begin
         vbus_charge_o     <= otg_q[ULTC_CHG_BIT];
         vbus_drain_o      <= otg_q[ULTC_DIS_BIT];
         hs_swing_adjust_o <= boost_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rx_bit_o       <= 1'b0;
         rx_bit_valid_o <= 1'b0;
         line_state_o   <= 2'h0;
      end else if (clk_en_i) begin
         line_state_o <= {se_dm_i, se_dp_i};
         if (xs == ULTC_XS_HS) begin
            rx_bit_o       <= hs_rx_data_i;
            rx_bit_valid_o <= !squelch_i;
         end else begin
            rx_bit_o       <= fsls_rx_data_i;
            rx_bit_valid_o <= 1'b1;
         end
      end
   end

   ultc_tx_state_t tx_state_q;
   logic [7:0]     sh_q;
   logic [2:0]     bit_cnt_q;
   logic [2:0]     ones_q;
   logic           stuff_on;

   assign stuff_on = (op != ULTC_OP_NOSTF);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tx_state_q   <= ULTC_TX_IDLE;
         sh_q         <= 8'h00;
         bit_cnt_q    <= 3'h0;
         ones_q       <= 3'h0;
         tx_line_o    <= 1'b1;
         tx_ready_o   <= 1'b0;
         hs_tx_en_o   <= 1'b0;
         fsls_tx_en_o <= 1'b0;
      end else if (clk_en_i) begin
         tx_ready_o <= 1'b0;
         case (tx_state_q)
            ULTC_TX_IDLE: begin
               hs_tx_en_o   <= 1'b0;
               fsls_tx_en_o <= 1'b0;
               if (tx_valid_i && tx_enable && op != ULTC_OP_NODRV && !tx_ready_o) begin
                  sh_q       <= tx_data_i;
                  bit_cnt_q  <= 3'h0;
                  tx_ready_o <= 1'b1;
                  tx_state_q <= ULTC_TX_SHIFT;
               end
            end
            ULTC_TX_SHIFT: begin
               hs_tx_en_o   <= (xs == ULTC_XS_HS);
               fsls_tx_en_o <= (xs != ULTC_XS_HS);
               // NRZI: zero toggles the line
               if (!sh_q[0]) begin
                  tx_line_o <= !tx_line_o;
                  ones_q    <= 3'h0;
               end else begin
                  ones_q    <= ones_q + 3'h1;
               end
               sh_q      <= {1'b0, sh_q[7:1]};
               bit_cnt_q <= bit_cnt_q + 3'h1;
               if (stuff_on && sh_q[0] && ones_q == ULTC_STUFF_MAX - 3'h1) begin
                  tx_state_q <= ULTC_TX_STUFF;
               end else if (bit_cnt_q == 3'h7) begin
                  tx_state_q <= ULTC_TX_IDLE;
               end
            end
            ULTC_TX_STUFF: begin
               tx_line_o <= !tx_line_o;
               ones_q    <= 3'h0;
               if (bit_cnt_q == 3'h0) begin
                  tx_state_q <= ULTC_TX_IDLE;
               end else begin
                  tx_state_q <= ULTC_TX_SHIFT;
               end
            end
            default: begin
               tx_state_q <= ULTC_TX_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- hw/ultc_pkg.sv ----
package ultc_pkg;
   // Register byte addresses
   localparam logic [11:0] ULTC_ADDR_FUNC   = 12'h000;
   localparam logic [11:0] ULTC_ADDR_OTG    = 12'h004;
   localparam logic [11:0] ULTC_ADDR_BOOST  = 12'h008;
   localparam logic [11:0] ULTC_ADDR_STATUS = 12'h00C;

   // Function control fields
   localparam int ULTC_XS_LSB   = 0;
   localparam int ULTC_TERM_BIT = 2;
   localparam int ULTC_OP_LSB   = 3;
   localparam int ULTC_TXEN_BIT = 5;
   // Line control fields
   localparam int ULTC_DPPD_BIT = 0;
   localparam int ULTC_DMPD_BIT = 1;
   localparam int ULTC_CHG_BIT  = 2;
   localparam int ULTC_DIS_BIT  = 3;
   // Status fields
   localparam int ULTC_ST_RES_LSB = 0;
   localparam int ULTC_ST_SQ_BIT  = 5;
   localparam int ULTC_ST_LS_LSB  = 6;

   localparam logic [5:0] ULTC_FUNC_RST  = 6'h01;
   localparam logic [3:0] ULTC_OTG_RST   = 4'h3;
   localparam logic [2:0] ULTC_BOOST_RST = 3'h0;

   localparam logic [1:0] ULTC_XS_HS = 2'h0;
   localparam logic [1:0] ULTC_XS_FS = 2'h1;
   localparam logic [1:0] ULTC_XS_LS = 2'h2;
   localparam logic [1:0] ULTC_OP_NORM  = 2'h0;
   localparam logic [1:0] ULTC_OP_NODRV = 2'h1;
   localparam logic [1:0] ULTC_OP_NOSTF = 2'h2;

   // Resistor enable bit positions
   localparam int ULTC_R_PUDP = 4;
   localparam int ULTC_R_PUDM = 3;
   localparam int ULTC_R_PDDP = 2;
   localparam int ULTC_R_PDDM = 1;
   localparam int ULTC_R_HST  = 0;

   localparam logic [2:0] ULTC_STUFF_MAX = 3'h6;

   typedef enum logic [1:0] {
      ULTC_TX_IDLE  = 2'b00,
      ULTC_TX_SHIFT = 2'b01,
      ULTC_TX_STUFF = 2'b10
   } ultc_tx_state_t;
endpackage

// ---- hw/ultc_decode.sv ----
`timescale 1ns/1ps
module ultc_decode (
   input  wire logic [1:0] speed_class_select_i,       // Speed class
   input  wire logic       fs_termination_choice_i,    // Termination choice
   input  wire logic [1:0] drive_operation_code_i,     // Operation code
   input  wire logic       plus_line_sink_request_i,   // DP pull-down request
   input  wire logic       minus_line_sink_request_i,  // DM pull-down request
   output logic      [4:0] enables_o                   // {pu_dp,pu_dm,pd_dp,pd_dm,hst}
);
   import ultc_pkg::*;
   logic [1:0] xs;
   logic       ts;
   logic [1:0] op;
   logic       nrm_or_chirp;
   logic [4:0] periph;

   always_comb begin
      xs           = speed_class_select_i;
      ts           = fs_termination_choice_i;
      op           = drive_operation_code_i;
      nrm_or_chirp = (op == ULTC_OP_NORM) || (op == ULTC_OP_NOSTF);
      periph       = 5'h00;
      enables_o    = 5'h00;
      if (op == ULTC_OP_NODRV) begin
         enables_o = 5'h00;
      end else if (plus_line_sink_request_i && minus_line_sink_request_i) begin
         if (xs == ULTC_XS_FS && !ts && op == ULTC_OP_NORM) begin
            enables_o = 5'h06;
         end else if (xs == ULTC_XS_HS && !ts && nrm_or_chirp) begin
            enables_o = 5'h07;
         end else if (xs[0] && ts && nrm_or_chirp && (op == ULTC_OP_NORM || xs == ULTC_XS_FS)) begin
            enables_o = 5'h06;
         end else if (xs == ULTC_XS_LS && ts && nrm_or_chirp) begin
            enables_o = 5'h06;
         end
      end else if (!plus_line_sink_request_i) begin
         if (xs == ULTC_XS_HS && ts && op == ULTC_OP_NOSTF) begin
            periph = 5'h10;
         end else if (xs == ULTC_XS_HS && !ts && nrm_or_chirp) begin
            periph = 5'h01;
         end else if (xs == ULTC_XS_FS && ts && nrm_or_chirp) begin
            periph = 5'h10;
         // peripheral LS modes (not for OTG)
         end else if (xs == ULTC_XS_LS && ts && nrm_or_chirp && !minus_line_sink_request_i) begin
            periph = 5'h08;
         end
         if (periph != 5'h00 && minus_line_sink_request_i) begin
            enables_o = periph | 5'h02;
         end else begin
            enables_o = periph;
         end
      end
   end
endmodule

// ---- dv/ultc_asserts.sv ----
`timescale 1ns/1ps
module ultc_asserts
   import ultc_pkg::*;
(
   input wire logic        clk_i,                    // Clock
   input wire logic        reset_i,                  // Reset
   input wire logic        psel_i,                   // Select
   input wire logic        penable_i,                // Enable
   input wire logic        pwrite_i,                 // Write
   input wire logic [11:0] paddr_i,                  // Address
   input wire logic [31:0] pwdata_i,                 // Data
   input wire logic        pready_o,                 // Ready
   input wire logic        hs_rx_data_i,             // HS bit
   input wire logic        fsls_rx_data_i,           // FS bit
   input wire logic        squelch_i,                // Squelch
   input wire logic        tx_valid_i,               // Byte valid
   input wire logic        tx_ready_o,               // Byte taken
   input wire logic        rx_bit_o,                 // Rx bit
   input wire logic        rx_bit_valid_o,           // Rx valid
   input wire logic        plus_line_strong_lift_o,  // DP up
   input wire logic        minus_line_strong_lift_o, // DM up
   input wire logic        plus_line_ground_leg_o,   // DP down
   input wire logic        minus_line_ground_leg_o,  // DM down
   input wire logic        hs_line_termination_o     // HS term
);
   logic [1:0] xs_q;
   logic [4:0] en;
   logic       wr_func;
   logic       rx_sel;
   logic       vld_sel;
   assign en = {plus_line_strong_lift_o, minus_line_strong_lift_o, plus_line_ground_leg_o,
                minus_line_ground_leg_o, hs_line_termination_o};
   assign wr_func = psel_i && penable_i && pready_o && pwrite_i && paddr_i == ULTC_ADDR_FUNC;
   assign rx_sel = (xs_q == ULTC_XS_HS) ? hs_rx_data_i : fsls_rx_data_i;
   assign vld_sel = (xs_q != ULTC_XS_HS) || !squelch_i;
   // Shadow of speed class; clk_en_i is assumed high
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         xs_q <= ULTC_XS_FS;
      end else if (wr_func) begin
         xs_q <= pwdata_i[1:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   AST_READY: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   AST_NODRV: assert property (wr_func && pwdata_i[4:3] == ULTC_OP_NODRV |-> ##2 en == 5'h00)
      else $error("enables on with drivers off");
   AST_RST_PD: assert property ($fell(reset_i) |-> ##[1:3] en == 5'h06)
      else $error("pull-downs missing after reset");
   AST_HST: assert property (hs_line_termination_o |-> !plus_line_strong_lift_o && !minus_line_strong_lift_o)
      else $error("termination with pull-up");
   AST_PU: assert property (plus_line_strong_lift_o |-> !minus_line_strong_lift_o && !plus_line_ground_leg_o
      && !hs_line_termination_o)
      else $error("DP pull-up with conflicting resistor");
   AST_RXSEL: assert property (!$past(reset_i) |-> rx_bit_o == $past(rx_sel))
      else $error("wrong receiver selected");
   AST_SQ: assert property (!$past(reset_i) |-> rx_bit_valid_o == $past(vld_sel))
      else $error("squelch gating wrong");
   AST_TXRDY: assert property (tx_ready_o |-> $past(tx_valid_i) ##1 !tx_ready_o)
      else $error("bad byte acceptance pulse");
endmodule
bind ultc_top ultc_asserts u_chk (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .pready_o, .hs_rx_data_i, .fsls_rx_data_i, .squelch_i, .tx_valid_i, .tx_ready_o, .rx_bit_o,
   .rx_bit_valid_o, .plus_line_strong_lift_o, .minus_line_strong_lift_o, .plus_line_ground_leg_o,
   .minus_line_ground_leg_o, .hs_line_termination_o);

// ---- dv/ultc_cable_model.sv ----
`timescale 1ns/1ps
module ultc_cable_model #(
   parameter int SEED = 28
) (
   input  wire logic clk_i,     // Clock
   input  wire logic reset_i,   // Reset
   output logic      hs_o,      // HS bit
   output logic      fsls_o,    // FS bit
   output logic      squelch_o, // No HS signal
   output logic      se_dp_o,   // DP level
   output logic      se_dm_o    // DM level
);
   int         seed = SEED;
   logic [4:0] line_q = 5'h05;
   assign {hs_o, fsls_o, squelch_o, se_dm_o, se_dp_o} = line_q;
   // Idle J in reset, then noise; squelch flips freely to stress gating
   always @(posedge clk_i) begin
      if (reset_i) begin
         line_q <= 5'h05;
      end else begin
         line_q <= 5'($random(seed));
      end
   end
endmodule

// ---- dv/tb_usb_line_termination_control.sv ----
`timescale 1ns/1ps
module tb_usb_line_termination_control;
   import ultc_pkg::*;
   logic        clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
   logic        pwrite_i = 1'b0, tx_valid_i = 1'b0, err;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
   logic [7:0]  tx_data_i = 8'h00;
   logic [2:0]  hs_swing_adjust_o;
   logic [1:0]  line_state_o;
   logic        pready_o, pslverr_o, tx_ready_o, rx_bit_o, rx_bit_valid_o, hs_tx_en_o, fsls_tx_en_o, tx_line_o;
   logic        vbus_charge_o, vbus_drain_o, hs_rx_data_i, fsls_rx_data_i, squelch_i, se_dp_i, se_dm_i;
   logic        plus_line_strong_lift_o, minus_line_strong_lift_o, plus_line_ground_leg_o;
   logic        minus_line_ground_leg_o, hs_line_termination_o;
   logic [4:0]  en;
   logic [5:0]  f;
   logic [3:0]  o;
   logic [1:0]  ls_q;
   int          fails = 0, n_compared = 0, cyc = 0, seed = 28, k, t, r;
   assign en = {plus_line_strong_lift_o, minus_line_strong_lift_o, plus_line_ground_leg_o,
                minus_line_ground_leg_o, hs_line_termination_o};
   ultc_top DUT (.clk_i, .reset_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .hs_rx_data_i, .fsls_rx_data_i, .squelch_i, .se_dp_i, .se_dm_i, .tx_valid_i,
      .tx_data_i, .tx_ready_o, .rx_bit_o, .rx_bit_valid_o, .line_state_o, .hs_tx_en_o, .fsls_tx_en_o,
      .tx_line_o, .hs_swing_adjust_o, .plus_line_strong_lift_o, .minus_line_strong_lift_o,
      .plus_line_ground_leg_o, .minus_line_ground_leg_o, .hs_line_termination_o, .vbus_charge_o,
      .vbus_drain_o);
   ultc_cable_model u_cable (.clk_i, .reset_i, .hs_o(hs_rx_data_i), .fsls_o(fsls_rx_data_i),
      .squelch_o(squelch_i), .se_dp_o(se_dp_i), .se_dm_o(se_dm_i));
   initial forever #5 clk_i = ~clk_i;
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      ls_q <= {se_dm_i, se_dp_i};
      if (cyc == 6000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Idle cycle after each transfer keeps psel from being driven twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (pready_o !== 1'b1 && t < 50);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic logic [4:0] ref_en(input logic [5:0] a, input logic [1:0] s);
      logic [4:0] e;
      e = 5'h00;
      if (a[3])
         return 5'h00;
      if (s == 2'h3) begin
         if (a[2:0] == 3'h0)
            e = 5'h07;
         else if (a[2:0] == 3'h1 && !a[4])
            e = 5'h06;
         else if (a[2] && (a[0] && !a[4] || a[1:0] == 2'h1 || a[1:0] == 2'h2))
            e = 5'h06;
      end else if (!s[0]) begin
         if (a[2:0] == 3'h4 && a[4])
            e = 5'h10;
         else if (a[2:0] == 3'h0)
            e = 5'h01;
         else if (a[2:0] == 3'h5)
            e = 5'h10;
         else if (a[2:0] == 3'h6 && !s[1])
            e = 5'h08;
         if (s[1] && e != 5'h00)
            e = e | 5'h02;
      end
      return e;
   endfunction
   // Counts line changes only while the FS driver is on; the line keeps its level in idle
   task automatic send(input logic [7:0] b, input int exp);
      int   n, hs;
      logic p;
      n = 0;
      hs = 0;
      tx_valid_i <= 1'b1;
      tx_data_i <= b;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (tx_ready_o !== 1'b1 && t < 20);
      chk("tx ready", 32'h1, 32'(tx_ready_o));
      tx_valid_i <= 1'b0;
      p = tx_line_o;
      repeat (14) begin
         @(posedge clk_i);
         if (fsls_tx_en_o === 1'b1 && tx_line_o !== p)
            n++;
         if (hs_tx_en_o !== 1'b0)
            hs++;
         p = tx_line_o;
      end
      chk("tx toggles", 32'(exp), 32'(n));
      chk("hs tx enable", 32'h0, 32'(hs));
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("reset enables", 32'h06, 32'(en));
      apb(1'b0, ULTC_ADDR_FUNC, 32'h0);
      chk("func reset", 32'(ULTC_FUNC_RST), rd);
      apb(1'b0, ULTC_ADDR_OTG, 32'h0);
      chk("otg reset", 32'(ULTC_OTG_RST), rd);
      $display("test reset done");
      // sweep holds all 128 combinations of the five decode fields, undefined ones too
      for (k = 0; k < 128; k++) begin
         r = $random(seed);
         f = {r[0], k[4:0]};
         o = {r[2:1], k[6:5]};
         apb(1'b1, ULTC_ADDR_OTG, 32'(o));
         apb(1'b1, ULTC_ADDR_FUNC, 32'(f));
         @(posedge clk_i);
         chk("resistor enables", 32'(ref_en(f, o[1:0])), 32'(en));
         chk("vbus controls", 32'(o[3:2]), 32'({vbus_drain_o, vbus_charge_o}));
         chk("line state", 32'(ls_q), 32'(line_state_o));
         apb(1'b0, ULTC_ADDR_STATUS, 32'h0);
         chk("status enables", 32'(ref_en(f, o[1:0])), 32'(rd[4:0]));
      end
      $display("test mode sweep done");
      r = $random(seed);
      apb(1'b1, ULTC_ADDR_BOOST, 32'(r[2:0]));
      @(posedge clk_i);
      chk("swing", 32'(r[2:0]), 32'(hs_swing_adjust_o));
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      chk("unmapped error", 32'h1, 32'(err));
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped read", 32'h0, rd);
      $display("test registers done");
      apb(1'b1, ULTC_ADDR_FUNC, 32'h25);
      send(8'h00, 8);
      send(8'hFF, 1);
      apb(1'b1, ULTC_ADDR_FUNC, 32'h35);
      send(8'hFF, 0);
      $display("test transmit done");
      end_of_test();
   end
endmodule
